// ---- design/tw_bus_engine.sv ----
`timescale 1ns/1ps
module tw_bus_engine #(
	parameter int HALF_CYC = tw_pkg::TW_SCL_HALF_CYC,
	parameter int TMR_W = 17
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic scl_oe_n,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic ctrl_wr,
	input wire tw_pkg::tw_ctrl_t ctrl_wdata,
	output tw_pkg::tw_ctrl_t ctrl,
	input wire logic data_wr,
	input wire logic [7:0] data_wdata,
	output logic [7:0] shift_byte,
	input wire logic [6:0] own_addr,
	input wire logic [1:0] rate_prescaler_field,
	output logic [7:0] status
);
	if (HALF_CYC < 1 || (HALF_CYC * 64) >= (2 ** TMR_W)) begin : g_chk
		$error("tw_bus_engine: HALF_CYC does not fit the timer");
	end

	////////////////////////////////////////////////////////////////////////
	// Pin sampling and bus condition detection
	logic [1:0] pin_s;
	logic scl_d, sda_d, bus_busy;
	logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;

	tw_sync #(.W(2)) u_sync (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.d({scl_in, sda_in}),
		.q(pin_s)
	);

	assign scl_s = pin_s[1];
	assign sda_s = pin_s[0];
	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_det = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			bus_busy <= 1'b0;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
			if (start_det)
				bus_busy <= 1'b1;
			else if (stop_det)
				bus_busy <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Engine state
	tw_pkg::tw_state_t state;
	logic [3:0] cnt;
	logic [1:0] step;
	logic [TMR_W-1:0] tmr;
	logic [TMR_W-1:0] half_cyc;
	logic [7:0] shift;
	logic [7:0] code;
	logic master, tx, addr_phase, addressed, rw, arb_lost;
	logic ack_out, ack_in, bus_err, set_job;
	logic tmr_done, release_job, need_addr, next_tx, ack_v, addr_hit;

	assign half_cyc = TMR_W'(HALF_CYC) << {rate_prescaler_field, 1'b0};
	assign tmr_done = tmr >= (half_cyc - 1'b1);
	assign release_job = ctrl_wr & ctrl_wdata.job_done_flag &
		ctrl.job_done_flag;
	assign need_addr = (code == tw_pkg::TW_ST_START) ||
		(code == tw_pkg::TW_ST_RSTART);
	assign next_tx = need_addr | (master ? ~rw : rw);
	assign addr_hit = (shift[7:1] == own_addr) & ctrl.ack_enable_bit;
	assign ack_v = addr_phase ? (~master & addr_hit) :
		((master | addressed) & ack_out);
	assign shift_byte = shift;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state <= tw_pkg::TW_S_IDLE;
			cnt <= 4'h0;
			step <= 2'h0;
			tmr <= '0;
			shift <= tw_pkg::TW_SHIFT_RST;
			code <= tw_pkg::TW_ST_NO_INFO;
			master <= 1'b0;
			tx <= 1'b0;
			addr_phase <= 1'b0;
			addressed <= 1'b0;
			rw <= 1'b0;
			arb_lost <= 1'b0;
			ack_out <= 1'b0;
			ack_in <= 1'b0;
			bus_err <= 1'b0;
			set_job <= 1'b0;
			scl_oe_n <= 1'b1;
			sda_oe_n <= 1'b1;
		end else begin
			set_job <= 1'b0;
			if (data_wr && ctrl.job_done_flag)
				shift <= data_wdata;
			if (!ctrl.enable) begin
				state <= tw_pkg::TW_S_IDLE;
				scl_oe_n <= 1'b1;
				sda_oe_n <= 1'b1;
				master <= 1'b0;
				addressed <= 1'b0;
			end else begin
				unique case (state)
				tw_pkg::TW_S_IDLE: begin
					scl_oe_n <= 1'b1;
					sda_oe_n <= 1'b1;
					master <= 1'b0;
					tmr <= '0;
					if (start_det) begin
						state <= tw_pkg::TW_S_BYTE;
						cnt <= 4'h0;
						addr_phase <= 1'b1;
						tx <= 1'b0;
						addressed <= 1'b0;
						arb_lost <= 1'b0;
					end else if (ctrl.start_request_bit && !bus_busy) begin
						state <= tw_pkg::TW_S_START;
						step <= 2'h2;
					end
				end
				tw_pkg::TW_S_START: begin
					tmr <= tmr + 1'b1;
					unique case (step)
					2'h0: begin
						sda_oe_n <= 1'b1;
						if (tmr_done) begin
							scl_oe_n <= 1'b1;
							step <= 2'h1;
							tmr <= '0;
						end
					end
					2'h1: begin
						if (!scl_s) begin
							tmr <= '0;
						end else if (tmr_done) begin
							step <= 2'h2;
							tmr <= '0;
						end
					end
					2'h2: begin
						sda_oe_n <= 1'b0;
						if (tmr_done) begin
							scl_oe_n <= 1'b0;
							state <= tw_pkg::TW_S_HOLD;
							master <= 1'b1;
							code <= master ? tw_pkg::TW_ST_RSTART :
								tw_pkg::TW_ST_START;
							set_job <= 1'b1;
						end
					end
					default: state <= tw_pkg::TW_S_IDLE;
					endcase
				end
				tw_pkg::TW_S_STOP: begin
					tmr <= tmr + 1'b1;
					unique case (step)
					2'h0: begin
						sda_oe_n <= 1'b0;
						if (tmr_done) begin
							scl_oe_n <= 1'b1;
							step <= 2'h1;
							tmr <= '0;
						end
					end
					2'h1: begin
						if (!scl_s) begin
							tmr <= '0;
						end else if (tmr_done) begin
							sda_oe_n <= 1'b1;
							step <= 2'h2;
							tmr <= '0;
						end
					end
					2'h2: begin
						if (tmr_done) begin
							state <= tw_pkg::TW_S_IDLE;
							master <= 1'b0;
						end
					end
					default: state <= tw_pkg::TW_S_IDLE;
					endcase
				end
				tw_pkg::TW_S_HOLD: begin
					// SCL stays as set on entry until software answers
					tmr <= '0;
					if (release_job) begin
						bus_err <= 1'b0;
						if (ctrl_wdata.stop_request_bit) begin
							if (master && !bus_err) begin
								state <= tw_pkg::TW_S_STOP;
								step <= 2'h0;
							end else begin
								state <= tw_pkg::TW_S_IDLE;
								scl_oe_n <= 1'b1;
								sda_oe_n <= 1'b1;
								master <= 1'b0;
								addressed <= 1'b0;
							end
						end else if (ctrl_wdata.start_request_bit && master) begin
							state <= tw_pkg::TW_S_START;
							step <= 2'h0;
						end else if (!master && !addressed) begin
							state <= tw_pkg::TW_S_IDLE;
							scl_oe_n <= 1'b1;
							sda_oe_n <= 1'b1;
						end else begin
							state <= tw_pkg::TW_S_BYTE;
							cnt <= 4'h0;
							addr_phase <= need_addr;
							tx <= next_tx;
							ack_out <= ctrl_wdata.ack_enable_bit;
							sda_oe_n <= ~(next_tx & ~shift[7]);
							scl_oe_n <= ~master;
						end
					end
				end
				tw_pkg::TW_S_BYTE: begin
					if (master) begin
						tmr <= tmr + 1'b1;
						if (!scl_oe_n) begin
							if (tmr_done) begin
								scl_oe_n <= 1'b1;
								tmr <= '0;
							end
						end else if (!scl_s) begin
							tmr <= '0;
						end else if (tmr_done) begin
							scl_oe_n <= 1'b0;
							tmr <= '0;
						end
					end
					if ((start_det || stop_det) && cnt != 4'h0) begin
						state <= tw_pkg::TW_S_HOLD;
						code <= tw_pkg::TW_ST_BUS_ERROR;
						set_job <= 1'b1;
						bus_err <= 1'b1;
						scl_oe_n <= 1'b1;
						sda_oe_n <= 1'b1;
						master <= 1'b0;
						addressed <= 1'b0;
					end else if (start_det && !master) begin
						addr_phase <= 1'b1;
						tx <= 1'b0;
						addressed <= 1'b0;
						sda_oe_n <= 1'b1;
					end else if (stop_det && !master) begin
						sda_oe_n <= 1'b1;
						addressed <= 1'b0;
						if (addressed) begin
							state <= tw_pkg::TW_S_HOLD;
							code <= tw_pkg::TW_ST_SLV_STOP;
							set_job <= 1'b1;
						end else begin
							state <= tw_pkg::TW_S_IDLE;
						end
					end else begin
						if (scl_rise) begin
							if (cnt == 4'h8) begin
								ack_in <= ~sda_s;
							end else begin
								shift <= {shift[6:0], sda_s};
								if (master && tx && shift[7] && !sda_s) begin
									master <= 1'b0;
									arb_lost <= 1'b1;
									tx <= 1'b0;
									scl_oe_n <= 1'b1;
								end
							end
						end
						if (scl_fall) begin
							if (cnt < 4'h7) begin
								cnt <= cnt + 4'h1;
								sda_oe_n <= ~(tx & ~shift[7]);
							end else if (cnt == 4'h7) begin
								cnt <= 4'h8;
								rw <= shift[0];
								if (tx) begin
									sda_oe_n <= 1'b1;
								end else begin
									sda_oe_n <= ~ack_v;
									ack_out <= ack_v;
								end
								if (addr_phase && !master)
									addressed <= addr_hit;
							end else begin
								cnt <= 4'h0;
								sda_oe_n <= 1'b1;
								arb_lost <= 1'b0;
								if (master) begin
									state <= tw_pkg::TW_S_HOLD;
									scl_oe_n <= 1'b0;
									set_job <= 1'b1;
									if (addr_phase)
										code <= rw ?
											(ack_in ? tw_pkg::TW_ST_MR_ADDR_ACK :
											tw_pkg::TW_ST_MR_ADDR_NACK) :
											(ack_in ? tw_pkg::TW_ST_MT_ADDR_ACK :
											tw_pkg::TW_ST_MT_ADDR_NACK);
									else if (tx)
										code <= ack_in ? tw_pkg::TW_ST_MT_DATA_ACK :
											tw_pkg::TW_ST_MT_DATA_NACK;
									else
										code <= ack_out ? tw_pkg::TW_ST_MR_DATA_ACK :
											tw_pkg::TW_ST_MR_DATA_NACK;
								end else if (addressed) begin
									state <= tw_pkg::TW_S_HOLD;
									scl_oe_n <= 1'b0;
									set_job <= 1'b1;
									if (addr_phase) begin
										code <= rw ? (arb_lost ?
											tw_pkg::TW_ST_ST_ADDR_ARB :
											tw_pkg::TW_ST_ST_ADDR) : (arb_lost ?
											tw_pkg::TW_ST_SR_ADDR_ARB :
											tw_pkg::TW_ST_SR_ADDR);
									end else if (tx) begin
										addressed <= ack_in & ack_out;
										code <= !ack_in ? tw_pkg::TW_ST_ST_DATA_NACK :
											(ack_out ? tw_pkg::TW_ST_ST_DATA_ACK :
											tw_pkg::TW_ST_ST_LAST_ACK);
									end else begin
										addressed <= ack_out;
										code <= ack_out ? tw_pkg::TW_ST_SR_DATA_ACK :
											tw_pkg::TW_ST_SR_DATA_NACK;
									end
								end else if (arb_lost) begin
									state <= tw_pkg::TW_S_HOLD;
									code <= tw_pkg::TW_ST_ARB_LOST;
									set_job <= 1'b1;
								end else begin
									state <= tw_pkg::TW_S_IDLE;
								end
							end
						end
					end
				end
				default: state <= tw_pkg::TW_S_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control register: hardware set of the job-done flag beats the clear
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ctrl <= tw_pkg::TW_CTRL_RST;
		end else begin
			if (ctrl_wr) begin
				ctrl.ack_enable_bit <= ctrl_wdata.ack_enable_bit;
				ctrl.start_request_bit <= ctrl_wdata.start_request_bit;
				ctrl.stop_request_bit <= ctrl_wdata.stop_request_bit &
					~(release_job & (bus_err | ~master));
				ctrl.enable <= ctrl_wdata.enable;
			end else if (state == tw_pkg::TW_S_STOP && step == 2'h2 &&
				tmr_done) begin
				ctrl.stop_request_bit <= 1'b0;
			end
			ctrl.job_done_flag <= set_job | (ctrl.job_done_flag &
				~(ctrl_wr & ctrl_wdata.job_done_flag));
			if (data_wr)
				ctrl.write_collision <= ~ctrl.job_done_flag;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status register and pin output levels
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			status <= tw_pkg::TW_ST_NO_INFO;
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			status[7:tw_pkg::TW_CODE_LSB] <= ctrl.job_done_flag ?
				code[7:tw_pkg::TW_CODE_LSB] :
				tw_pkg::TW_ST_NO_INFO[7:tw_pkg::TW_CODE_LSB];
			status[2] <= 1'b0;
			status[tw_pkg::TW_PRESC_W-1:0] <= rate_prescaler_field;
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end
	end
endmodule : tw_bus_engine

// ---- design/tw_pkg.sv ----
package tw_pkg;

	////////////////////////////////////////////////////////////////////////
	// Status codes (upper five bits significant, low three zero; status reads bit 2 as zero, bits 1:0 as the prescaler)
	localparam logic [7:0] TW_ST_NO_INFO = 8'hf8;
	localparam logic [7:0] TW_ST_BUS_ERROR = 8'h00;
	localparam logic [7:0] TW_ST_START = 8'h08;
	localparam logic [7:0] TW_ST_RSTART = 8'h10;
	localparam logic [7:0] TW_ST_MT_ADDR_ACK = 8'h18;
	localparam logic [7:0] TW_ST_MT_ADDR_NACK = 8'h20;
	localparam logic [7:0] TW_ST_MT_DATA_ACK = 8'h28;
	localparam logic [7:0] TW_ST_MT_DATA_NACK = 8'h30;
	localparam logic [7:0] TW_ST_ARB_LOST = 8'h38;
	localparam logic [7:0] TW_ST_MR_ADDR_ACK = 8'h40;
	localparam logic [7:0] TW_ST_MR_ADDR_NACK = 8'h48;
	localparam logic [7:0] TW_ST_MR_DATA_ACK = 8'h50;
	localparam logic [7:0] TW_ST_MR_DATA_NACK = 8'h58;
	localparam logic [7:0] TW_ST_SR_ADDR = 8'h60;
	localparam logic [7:0] TW_ST_SR_ADDR_ARB = 8'h68;
	localparam logic [7:0] TW_ST_SR_DATA_ACK = 8'h80;
	localparam logic [7:0] TW_ST_SR_DATA_NACK = 8'h88;
	localparam logic [7:0] TW_ST_SLV_STOP = 8'ha0;
	localparam logic [7:0] TW_ST_ST_ADDR = 8'ha8;
	localparam logic [7:0] TW_ST_ST_ADDR_ARB = 8'hb0;
	localparam logic [7:0] TW_ST_ST_DATA_ACK = 8'hb8;
	localparam logic [7:0] TW_ST_ST_DATA_NACK = 8'hc0;
	localparam logic [7:0] TW_ST_ST_LAST_ACK = 8'hc8;

	////////////////////////////////////////////////////////////////////////
	// Status register layout
	localparam int TW_CODE_LSB = 3;
	localparam int TW_CODE_W = 5;
	localparam int TW_PRESC_W = 2;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] TW_SHIFT_RST = 8'hff;
	localparam logic [5:0] TW_CTRL_RST = 6'h00;

	////////////////////////////////////////////////////////////////////////
	// Timing: half of the SCL period, a least time, rounded up
	localparam int TW_CLK_MHZ = 250;
	localparam int TW_SCL_HALF_NS = 5000;
	localparam int TW_SCL_HALF_CYC = (TW_SCL_HALF_NS * TW_CLK_MHZ + 999) / 1000;

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef struct packed {
		logic job_done_flag;
		logic ack_enable_bit;
		logic start_request_bit;
		logic stop_request_bit;
		logic write_collision;
		logic enable;
	} tw_ctrl_t;

	typedef enum logic [2:0] {
		TW_S_IDLE = 3'b000,
		TW_S_START = 3'b001,
		TW_S_BYTE = 3'b010,
		TW_S_HOLD = 3'b011,
		TW_S_STOP = 3'b100
	} tw_state_t;

endpackage : tw_pkg

// ---- design/tw_sync.sv ----
`timescale 1ns/1ps
module tw_sync #(
	parameter int W = 2
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	// Pins idle high, so both stages reset to one
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			meta <= '1;
			q <= '1;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : tw_sync

// ---- test/tw_bus_engine_chk.sv ----
`timescale 1ns/1ps
module tw_bus_engine_chk #(
	parameter int HALF_CYC = tw_pkg::TW_SCL_HALF_CYC,
	parameter int TMR_W = 17
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic scl_out,
	input wire logic scl_oe_n,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic ctrl_wr,
	input wire tw_pkg::tw_ctrl_t ctrl_wdata,
	input wire tw_pkg::tw_ctrl_t ctrl,
	input wire logic data_wr,
	input wire logic [7:0] data_wdata,
	input wire logic [7:0] shift_byte,
	input wire logic [6:0] own_addr,
	input wire logic [1:0] rate_prescaler_field,
	input wire logic [7:0] status
);
	logic [1:0] age;
	logic [4:0] code;
	logic rel;
	logic rec;
	assign code = status[7:3];
	assign rel = scl_oe_n && sda_oe_n;
	assign rec = ctrl_wr && ctrl.job_done_flag && code == 5'h00 &&
		ctrl_wdata.job_done_flag && ctrl_wdata.stop_request_bit &&
		!ctrl_wdata.start_request_bit;
	// Keeps history-based checks quiet just after each reset
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			age <= 2'h0;
		end else if (age != 2'h3) begin
			age <= age + 2'h1;
		end
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////
	AST_IDLE_CODE: assert property (
		age == 2'h3 && !$past(ctrl.job_done_flag) |-> code == 5'h1f)
		else $error("idle code missing");
	AST_PRESC: assert property (
		age == 2'h3 |-> status[2:0] == {1'b0, $past(rate_prescaler_field)})
		else $error("prescaler field wrong");
	AST_ERR_FLAG: assert property (
		age == 2'h3 && code == 5'h00 |-> $past(ctrl.job_done_flag))
		else $error("bus error without flag");
	AST_ERR_FREE: assert property (
		code == 5'h00 |-> rel)
		else $error("lines held after bus error");
	AST_RECOVER: assert property (
		rec |=> !ctrl.stop_request_bit && !ctrl.job_done_flag &&
		ctrl.ack_enable_bit == $past(ctrl_wdata.ack_enable_bit) && ctrl.enable)
		else $error("recovery write mishandled");
	AST_REC_FREE: assert property (
		rec |=> rel [*8])
		else $error("lines driven during recovery");
	AST_HOLD_SCL: assert property (
		ctrl.job_done_flag && $past(ctrl.job_done_flag) &&
		code != 5'h00 && code != 5'h07 && code != 5'h14 |-> !scl_oe_n)
		else $error("clock not stretched");
	AST_ARB_FREE: assert property (
		code == 5'h07 |-> rel)
		else $error("lines held after lost arbitration");
	AST_RSTART: assert property (
		ctrl_wr && ctrl.job_done_flag && code == 5'h03 &&
		ctrl_wdata.job_done_flag && ctrl_wdata.start_request_bit
		|-> ##[1:400] code == 5'h02)
		else $error("repeated start missing");
	AST_OUT_LOW: assert property (
		!scl_out && !sda_out)
		else $error("pin output level not low");
	C_ERR: cover property (code == 5'h00);
	C_ARB: cover property (code == 5'h07);
	C_RST: cover property (code == 5'h02);
endmodule : tw_bus_engine_chk

bind tw_bus_engine tw_bus_engine_chk #(.HALF_CYC(HALF_CYC),
	.TMR_W(TMR_W)) u_chk (
	.clk_sys(clk_sys), .arst_n(arst_n), .scl_in(scl_in), .sda_in(sda_in),
	.scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out),
	.sda_oe_n(sda_oe_n), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
	.ctrl(ctrl), .data_wr(data_wr), .data_wdata(data_wdata),
	.shift_byte(shift_byte), .own_addr(own_addr),
	.rate_prescaler_field(rate_prescaler_field), .status(status)
);

// ---- test/tw_peer.sv ----
`timescale 1ns/1ps
module tw_peer (
	input wire logic scl,
	input wire logic sda,
	output logic sda_oe_n
);
	int bits = -1;
	initial sda_oe_n = 1'b1;
	// Start restarts framing, stop ends it
	always @(sda) begin
		if (scl === 1'b1) begin
			bits = sda ? -1 : 0;
			sda_oe_n = 1'b1;
		end
	end
	// Acknowledge every byte by pulling SDA across the ninth clock
	always @(negedge scl) begin
		if (bits >= 0) begin
			bits = (bits == 9) ? 1 : bits + 1;
			sda_oe_n = (bits != 9);
		end
	end
endmodule : tw_peer

// ---- test/tw_bus_engine_tb.sv ----
`timescale 1ns/1ps
module tw_bus_engine_tb;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic ctrl_wr = 1'b0;
	logic data_wr = 1'b0;
	logic [7:0] data_wdata = 8'h00;
	logic [1:0] presc = 2'h1;
	logic tb_scl = 1'b1;
	logic tb_sda = 1'b1;
	tw_pkg::tw_ctrl_t ctrl_wdata = 6'h00;
	tw_pkg::tw_ctrl_t ctrl;
	logic scl_oe_n, sda_oe_n, peer_oe_n;
	logic [7:0] shift_byte, status;
	int error_cnt = 0;
	int samples_checked = 0;
	int cyc = 0;
	wire logic scl = scl_oe_n & tb_scl;
	wire logic sda = sda_oe_n & tb_sda & peer_oe_n;
	always #2 clk_sys = ~clk_sys;
	tw_bus_engine #(.HALF_CYC(4)) uut (
		.clk_sys(clk_sys), .arst_n(arst_n), .scl_in(scl), .sda_in(sda),
		.scl_out(), .scl_oe_n(scl_oe_n), .sda_out(), .sda_oe_n(sda_oe_n),
		.ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl(ctrl),
		.data_wr(data_wr), .data_wdata(data_wdata), .shift_byte(shift_byte),
		.own_addr(7'h2a), .rate_prescaler_field(presc), .status(status)
	);
	tw_peer u_peer (.scl(scl), .sda(sda), .sda_oe_n(peer_oe_n));
	////////////////////////////////////////
	task automatic tick(input int n = 1);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick
	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string m);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t %s: got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic wctl(input logic [5:0] v);
		ctrl_wdata = v;
		ctrl_wr = 1'b1;
		tick();
		ctrl_wr = 1'b0;
		tick();
	endtask : wctl
	task automatic wdat(input logic [7:0] v);
		data_wdata = v;
		data_wr = 1'b1;
		tick();
		data_wr = 1'b0;
		tick();
	endtask : wdat
	task automatic wait_done(input logic [7:0] exp, input string m);
		int n;
		n = 0;
		while (ctrl.job_done_flag !== 1'b1 && n < 3000) begin
			tick();
			n++;
		end
		tick(2);
		chk(status, exp, m);
	endtask : wait_done
	// One bit from the other master, 32 ns clock
	task automatic tbit(input logic b);
		tb_sda = b;
		#8 tb_scl = 1'b1;
		#16 tb_scl = 1'b0;
		#8;
	endtask : tbit
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : print_verdict
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end
	////////////////////////////////////////
	initial begin
		tick(12);
		arst_n = 1'b1;
		tick(4);
		chk(status, tw_pkg::TW_ST_NO_INFO | 8'h01, "idle status");
		chk({2'h0, ctrl}, 8'h00, "ctrl reset");
		chk(shift_byte, tw_pkg::TW_SHIFT_RST, "shift reset");
		chk({6'h0, scl_oe_n, sda_oe_n}, 8'h03, "lines free");
		presc = 2'h0;
		$display("test reset done");
		// Stray stop after three address bits
		wctl(6'h11);
		tb_sda = 1'b0;
		#16 tb_scl = 1'b0;
		#8;
		tbit(1'b1);
		tbit(1'b0);
		tbit(1'b1);
		tb_sda = 1'b0;
		#8 tb_scl = 1'b1;
		#8 tb_sda = 1'b1;
		tick();
		wait_done(tw_pkg::TW_ST_BUS_ERROR, "bus error");
		chk({7'h0, ctrl.job_done_flag}, 8'h01, "flag set");
		wctl(6'h35);
		chk({2'h0, ctrl}, 8'h11, "recovered ctrl");
		chk(status, tw_pkg::TW_ST_NO_INFO, "idle after recovery");
		tick(20);
		chk({6'h0, scl, sda}, 8'h03, "no stop driven");
		$display("test bus error done");
		wctl(6'h19);
		wait_done(tw_pkg::TW_ST_START, "start");
		chk({7'h0, scl_oe_n}, 8'h00, "scl held");
		wdat(8'ha0);
		wctl(6'h31);
		wait_done(tw_pkg::TW_ST_MT_ADDR_ACK, "addr ack");
		wctl(6'h39);
		wait_done(tw_pkg::TW_ST_RSTART, "repeated start");
		wdat(8'ha0);
		wctl(6'h31);
		wait_done(tw_pkg::TW_ST_MT_ADDR_ACK, "addr after rs");
		// Other master forces a zero under our leading one
		tb_sda = 1'b0;
		wdat(8'h80);
		wctl(6'h31);
		// Winning master clocks out the rest of its byte
		tick(12);
		tb_scl = 1'b0;
		#8;
		repeat (7) tbit(1'b0);
		tbit(1'b1);
		wait_done(tw_pkg::TW_ST_ARB_LOST, "arb lost");
		chk({6'h0, scl_oe_n, sda_oe_n}, 8'h03, "released");
		chk(shift_byte, 8'h00, "bus byte kept");
		wctl(6'h39);
		tick(30);
		chk(status, tw_pkg::TW_ST_NO_INFO, "waits for free bus");
		chk({7'h0, sda_oe_n}, 8'h01, "no start on busy bus");
		// Winning master ends its frame with a STOP
		tb_sda = 1'b0;
		#8 tb_scl = 1'b1;
		#8 tb_sda = 1'b1;
		wait_done(tw_pkg::TW_ST_START, "start after stop");
		wctl(6'h35);
		tick(40);
		chk({2'h0, ctrl}, 8'h11, "stop request cleared");
		chk({6'h0, scl, sda}, 8'h03, "bus free after stop");
		$display("test master done");
		print_verdict();
	end
endmodule : tw_bus_engine_tb
